// ### kbd_ctrl_defs.svh
// Constants of the keyboard serial controller: timing, field positions, reset values
`ifndef KBD_CTRL_DEFS_SVH
`define KBD_CTRL_DEFS_SVH

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define KBD_CLK_MHZ 40
`define KBD_INHIBIT_US 100
`define KBD_INHIBIT_CYC (`KBD_INHIBIT_US * `KBD_CLK_MHZ)
`define KBD_ACK_TIMEOUT_US 15000
`define KBD_ACK_TIMEOUT_CYC (`KBD_ACK_TIMEOUT_US * `KBD_CLK_MHZ)

// ----------------------------------------------------------------------------
// Frame layout
// ----------------------------------------------------------------------------
`define KBD_DATA_BITS 8
`define KBD_RX_FRAME_BITS 11
`define KBD_TX_PAR_EDGE 8
`define KBD_TX_STOP_EDGE 9

// ----------------------------------------------------------------------------
// Status byte fields and reset values
// ----------------------------------------------------------------------------
`define KBD_ST_OBF 0
`define KBD_ST_IBF 1
`define KBD_ST_PAR_ERR 2
`define KBD_ST_TX_ERR 3
`define KBD_STATUS_RST 8'h00
`define KBD_BYTE_RST 8'h00

// ----------------------------------------------------------------------------
// Translation
// ----------------------------------------------------------------------------
`define KBD_BREAK_PREFIX 8'hF0
`define KBD_BREAK_MASK 8'h80

`endif

// ### kbd_ctrl_pkg.sv
// Types shared by the keyboard serial controller modules
package kbd_ctrl_pkg;

  typedef logic [7:0] kbd_byte_t;

  // Gray coded along idle -> inhibit -> start -> send -> ack
  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_INHIBIT = 3'b001,
    ST_START   = 3'b011,
    ST_SEND    = 3'b010,
    ST_ACK     = 3'b110
  } tx_state_e;

endpackage : kbd_ctrl_pkg

// ### kbd_frame_if.sv
// Carrier between the controller and its receive frame shifter
`timescale 1ns/1ps
interface kbd_frame_if;
  import kbd_ctrl_pkg::*;
  logic bit_stb;
  logic bit_val;
  logic clr;
  logic busy;
  logic byte_vld;
  logic par_ok;
  kbd_byte_t rx_byte;

  modport shifter (input bit_stb, input bit_val, input clr,
                   output busy, output byte_vld, output par_ok, output rx_byte);
  modport ctrl (output bit_stb, output bit_val, output clr,
                input busy, input byte_vld, input par_ok, input rx_byte);
endinterface : kbd_frame_if

// ### kbd_rx_shifter.sv
// Receive frame shifter: start, eight data bits, odd parity, stop
`timescale 1ns/1ps
`include "kbd_ctrl_defs.svh"
module kbd_rx_shifter (
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  kbd_frame_if.shifter frm
);
  import kbd_ctrl_pkg::*;

  logic [3:0] cnt_q;
  logic [10:0] shift_q;
  logic vld_q;
  wire last_bit = (cnt_q == 4'(`KBD_RX_FRAME_BITS - 1));
  wire [10:0] frame_w = {frm.bit_val, shift_q[10:1]};

  // ---------------------------------------------------------------------------
  // Bit collection, LSB first, shifted in from the top
  // ---------------------------------------------------------------------------
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in || frm.clr) begin
      cnt_q <= 4'h0;
      shift_q <= 11'h000;
      vld_q <= 1'b0;
    end else begin
      vld_q <= frm.bit_stb && last_bit;
      if (frm.bit_stb) begin
        shift_q <= frame_w;
        cnt_q <= last_bit ? 4'h0 : cnt_q + 4'h1;
      end
    end
  end

  // Framing faults count as parity faults so no bad byte is ever delivered
  assign frm.busy = (cnt_q != 4'h0);
  assign frm.byte_vld = vld_q;
  assign frm.rx_byte = shift_q[8:1];
  assign frm.par_ok = (^shift_q[9:1]) && !shift_q[0] && shift_q[10];

endmodule : kbd_rx_shifter

// ### kbd_serial_ctrl.sv
// Keyboard serial controller: host buffers and the two-wire keyboard link
`timescale 1ns/1ps
`include "kbd_ctrl_defs.svh"
// Operation
// - Receive, parity-check, translate, buffer keyboard bytes
// - Output-buffer-full interrupts host or is polled
// - Host-written byte goes serially to keyboard
// - Every serial byte carries odd parity
// - Next byte waits for previous acknowledge or the acknowledge timeout
// - One buffer-full interrupt serves send and receive
module kbd_serial_ctrl #(
  parameter int unsigned ACK_TIMEOUT_CYC = `KBD_ACK_TIMEOUT_CYC
) (
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  input wire logic host_wr_in,
  input wire kbd_ctrl_pkg::kbd_byte_t host_wdata_in,
  input wire logic host_rd_in,
  input wire logic host_stat_rd_in,
  input wire logic irq_en_in,
  input wire logic xlat_en_in,
  output logic [7:0] status_out,
  output kbd_ctrl_pkg::kbd_byte_t out_data_out,
  output logic irq_out,
  input wire logic kb_clk_in,
  output logic kb_clk_out,
  output logic kb_clk_oe_out,
  input wire logic kb_data_in,
  output logic kb_data_out,
  output logic kb_data_oe_out
);
  import kbd_ctrl_pkg::*;

  // One timer serves both the inhibit and the timeout, so it must hold the longer count
  localparam int unsigned TMR_MAX = (ACK_TIMEOUT_CYC > `KBD_INHIBIT_CYC) ?
                                    ACK_TIMEOUT_CYC : `KBD_INHIBIT_CYC;
  localparam int TW = $clog2(TMR_MAX + 1);

  kbd_frame_if frm ();
  tx_state_e state_q, state_d;
  logic clk_s1_q, clk_s2_q, clk_s3_q, dat_s1_q, dat_s2_q;
  logic [TW-1:0] tmr_q;
  logic [3:0] edge_cnt_q;
  kbd_byte_t tx_byte_q, out_buf_q;
  logic obf_q, ibf_q, par_err_q, tx_err_q, brk_pend_q, irq_q, drv_low_q;
  logic clk_oe_q, data_oe_q, clk_oe_d, data_oe_d;
  logic [7:0] status_q;

  // ---------------------------------------------------------------------------
  // Link synchronisers; the link clock is only sampled, never used as a clock
  // ---------------------------------------------------------------------------
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      clk_s1_q <= 1'b1;
      clk_s2_q <= 1'b1;
      clk_s3_q <= 1'b1;
      dat_s1_q <= 1'b1;
      dat_s2_q <= 1'b1;
    end else begin
      clk_s1_q <= kb_clk_in;
      clk_s2_q <= clk_s1_q;
      clk_s3_q <= clk_s2_q;
      dat_s1_q <= kb_data_in;
      dat_s2_q <= dat_s1_q;
    end
  end

  // ---------------------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------------------
  wire fall = clk_s3_q && !clk_s2_q;
  wire inhibit_done = (tmr_q == TW'(`KBD_INHIBIT_CYC - 1));
  wire timeout = (tmr_q == TW'(ACK_TIMEOUT_CYC - 1));
  wire good_rx = frm.byte_vld && frm.par_ok;
  wire bad_rx = frm.byte_vld && !frm.par_ok;
  wire is_prefix = xlat_en_in && (frm.rx_byte == `KBD_BREAK_PREFIX);
  wire [7:0] xlat_byte = (xlat_en_in && brk_pend_q) ?
                         (frm.rx_byte | `KBD_BREAK_MASK) : frm.rx_byte;
  wire load_ob = good_rx && !is_prefix;
  wire tx_go = (state_q == ST_IDLE) && ibf_q && !frm.busy;
  wire ack_seen = (state_q == ST_ACK) && fall;
  wire tx_abort = timeout && (state_q != ST_IDLE) && (state_q != ST_INHIBIT);
  wire tx_done = ack_seen || tx_abort;
  wire obf_d = load_ob || (obf_q && !host_rd_in);
  wire ibf_d = (host_wr_in && !ibf_q) || (ibf_q && !tx_done);
  wire par_err_d = bad_rx || (par_err_q && !host_stat_rd_in);
  wire tx_err_d = tx_abort || (ack_seen && dat_s2_q) || (tx_err_q && !host_stat_rd_in);

  // Receiving only while idle and not holding the keyboard off
  assign frm.bit_stb = fall && (state_q == ST_IDLE) && !clk_oe_q;
  assign frm.bit_val = dat_s2_q;
  assign frm.clr = (state_q != ST_IDLE);

  kbd_rx_shifter u_rx (
    .ref_clk_in (ref_clk_in),
    .sys_rst_in (sys_rst_in),
    .frm (frm.shifter)
  );

  // ---------------------------------------------------------------------------
  // Transmit sequencer
  // ---------------------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    clk_oe_d = clk_oe_q;
    data_oe_d = data_oe_q;
    case (state_q)
      ST_IDLE: begin
        // A full output buffer holds the clock low: the keyboard may not send
        clk_oe_d = obf_d;
        data_oe_d = 1'b0;
        if (tx_go) begin
          state_d = ST_INHIBIT;
          clk_oe_d = 1'b1;
        end
      end
      ST_INHIBIT: begin
        clk_oe_d = 1'b1;
        if (inhibit_done) begin
          state_d = ST_START;
          data_oe_d = 1'b1;
        end
      end
      ST_START: begin
        clk_oe_d = 1'b0;
        state_d = ST_SEND;
      end
      ST_SEND: begin
        if (fall) begin
          if (edge_cnt_q < 4'(`KBD_DATA_BITS)) begin
            data_oe_d = !tx_byte_q[edge_cnt_q[2:0]];
          end else if (edge_cnt_q == 4'(`KBD_TX_PAR_EDGE)) begin
            data_oe_d = ^tx_byte_q;
          end else begin
            data_oe_d = 1'b0;
            state_d = ST_ACK;
          end
        end
      end
      ST_ACK: begin
        data_oe_d = 1'b0;
        if (ack_seen) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
        clk_oe_d = 1'b0;
        data_oe_d = 1'b0;
      end
    endcase
    if (tx_abort) begin
      state_d = ST_IDLE;
      clk_oe_d = 1'b0;
      data_oe_d = 1'b0;
    end
  end

  // Sequencer state, timer and edge counter
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      state_q <= ST_IDLE;
      tmr_q <= '0;
      edge_cnt_q <= 4'h0;
      clk_oe_q <= 1'b0;
      data_oe_q <= 1'b0;
    end else begin
      state_q <= state_d;
      tmr_q <= (state_d != state_q) ? '0 : tmr_q + TW'(1);
      edge_cnt_q <= (state_q != ST_SEND) ? 4'h0 : edge_cnt_q + 4'(fall);
      clk_oe_q <= clk_oe_d;
      data_oe_q <= data_oe_d;
    end
  end

  // ---------------------------------------------------------------------------
  // Host buffers and status; every set wins over a clear in the same cycle
  // ---------------------------------------------------------------------------
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      obf_q <= 1'b0;
      ibf_q <= 1'b0;
      par_err_q <= 1'b0;
      tx_err_q <= 1'b0;
      brk_pend_q <= 1'b0;
      out_buf_q <= `KBD_BYTE_RST;
      tx_byte_q <= `KBD_BYTE_RST;
      status_q <= `KBD_STATUS_RST;
      irq_q <= 1'b0;
      drv_low_q <= 1'b0;
    end else begin
      obf_q <= obf_d;
      ibf_q <= ibf_d;
      par_err_q <= par_err_d;
      tx_err_q <= tx_err_d;
      drv_low_q <= 1'b0;
      if (good_rx) begin
        brk_pend_q <= is_prefix;
      end
      if (load_ob) begin
        out_buf_q <= xlat_byte;
      end
      if (host_wr_in && !ibf_q) begin
        tx_byte_q <= host_wdata_in;
      end
      status_q <= {4'h0, tx_err_d, par_err_d, ibf_d, obf_d};
      // The keyboard's reply to a sent byte lands here too, so one source serves
      irq_q <= irq_en_in && obf_d;
    end
  end

  // Open-drain link: the output level is always low, the enables drive
  assign kb_clk_out = drv_low_q;
  assign kb_data_out = drv_low_q;
  assign kb_clk_oe_out = clk_oe_q;
  assign kb_data_oe_out = data_oe_q;
  assign out_data_out = out_buf_q;
  assign status_out = status_q;
  assign irq_out = irq_q;

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (sys_rst_in);

  sequence s_launch;
    (state_q == ST_INHIBIT) && clk_oe_q;
  endsequence
  sequence s_acked;
    (state_q == ST_IDLE) && !ibf_q;
  endsequence

  a_rx_byte_lands: assert property (load_ob |=> obf_q
    && out_buf_q[6:0] == $past(frm.rx_byte[6:0])) else $error("byte not buffered");
  a_irq_on_full: assert property ($rose(obf_q) && $past(irq_en_in) |-> irq_q)
    else $error("no interrupt on full");
  a_tx_launch: assert property (tx_go && !tx_abort |=> s_launch)
    else $error("send not started");
  a_tx_parity: assert property ((state_q == ST_SEND) && fall
    && edge_cnt_q == 4'(`KBD_TX_PAR_EDGE) |=> data_oe_q == ^$past(tx_byte_q))
    else $error("parity bit wrong");
  a_ack_frees: assert property (ack_seen |=> s_acked)
    else $error("ack did not free buffer");
  a_busy_refuse: assert property (ibf_q && host_wr_in |=> tx_byte_q == $past(tx_byte_q))
    else $error("byte overwritten before ack");
  a_single_irq: assert property (irq_q |-> obf_q && $past(irq_en_in))
    else $error("interrupt without full buffer");
  a_par_reject: assert property (bad_rx && !host_rd_in |=> par_err_q
    && obf_q == $past(obf_q) && out_buf_q == $past(out_buf_q))
    else $error("bad byte accepted");

endmodule : kbd_serial_ctrl

// ### kb_model.sv
// Keyboard model on the two-wire link: sends frames, clocks in host bytes
`timescale 1ns/1ps
module kb_model (
  input wire logic clk_w_in,
  input wire logic data_w_in,
  output logic clk_pull_out,
  output logic data_pull_out
);
  // Both wires released at start; pull-ups give the idle high level
  initial begin
    clk_pull_out = 1'b0;
    data_pull_out = 1'b0;
  end

  // Start, eight bits LSB first, parity, stop; clock stands high after
  task automatic send(input logic [7:0] b, input logic bad_par);
    logic [10:0] f;
    f = {1'b1, ~^b ^ bad_par, b, 1'b0};
    wait (clk_w_in);
    for (int i = 0; i < 11; i++) begin
      data_pull_out = ~f[i];
      #100 clk_pull_out = 1'b1;
      #100 clk_pull_out = 1'b0;
    end
    data_pull_out = 1'b0;
  endtask : send

  // Waits for a request to send, samples late in each high phase
  task automatic recv(input logic ack, output logic [10:0] f);
    wait (!clk_w_in);
    wait (clk_w_in && !data_w_in);
    for (int i = 0; i < 11; i++) begin
      #90 f[i] = data_w_in;
      if (i == 10) data_pull_out = ack;
      #10 clk_pull_out = 1'b1;
      #100 clk_pull_out = 1'b0;
    end
    data_pull_out = 1'b0;
  endtask : recv
endmodule : kb_model

// ### test_keyboard_serial_controller.sv
// Self-checking bench of the keyboard serial controller
`timescale 1ns/1ps
module test_keyboard_serial_controller;
  import kbd_ctrl_pkg::*;
  logic ref_clk, rst, wr, rd, srd, irq_en, xlat;
  kbd_byte_t wdata, odata;
  logic [7:0] status;
  logic irq, c_oe, d_oe, c_pull, d_pull, c_w, d_w;
  logic [10:0] fr;
  int mismatches = 0;
  int n_checks = 0;

  // Open-drain wires: low while either side pulls
  assign c_w = !(c_oe || c_pull);
  assign d_w = !(d_oe || d_pull);

  kbd_serial_ctrl #(.ACK_TIMEOUT_CYC(2000)) DUT (
    .ref_clk_in(ref_clk), .sys_rst_in(rst), .host_wr_in(wr),
    .host_wdata_in(wdata), .host_rd_in(rd), .host_stat_rd_in(srd),
    .irq_en_in(irq_en), .xlat_en_in(xlat), .status_out(status),
    .out_data_out(odata), .irq_out(irq), .kb_clk_in(c_w), .kb_clk_out(),
    .kb_clk_oe_out(c_oe), .kb_data_in(d_w), .kb_data_out(),
    .kb_data_oe_out(d_oe));

  kb_model kb (.clk_w_in(c_w), .data_w_in(d_w), .clk_pull_out(c_pull),
    .data_pull_out(d_pull));

  task automatic chk(input logic ok, input string what);
    n_checks++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("CHECK FAILED at %0t: %s", $time, what);
    end
  endtask : chk

  task automatic pulse(ref logic s);
    @(posedge ref_clk);
    #1 s = 1'b1;
    @(posedge ref_clk);
    #1 s = 1'b0;
  endtask : pulse

  task automatic host_send(input kbd_byte_t b);
    @(posedge ref_clk);
    #1 wdata = b;
    wr = 1'b1;
    @(posedge ref_clk);
    #1 wr = 1'b0;
  endtask : host_send

  // Bounded wait on one status bit, then judged
  task automatic wait_st(input int b, input logic v, input int lim);
    int n;
    n = 0;
    while (status[b] !== v && n < lim) begin
      @(posedge ref_clk);
      #1 n++;
    end
    chk(status[b] === v, "status bit wait");
  endtask : wait_st

  task automatic t_rx(input kbd_byte_t b, input logic ie);
    irq_en = ie;
    kb.send(b, 1'b0);
    wait_st(0, 1'b1, 40);
    chk(odata === b, "received byte");
    chk(irq === ie, "interrupt or polled");
    pulse(rd);
    repeat (2) @(posedge ref_clk);
    #1;
    chk(status[0] === 1'b0 && irq === 1'b0, "read clears full");
  endtask : t_rx

  task automatic t_par();
    kb.send(8'h3C, 1'b1);
    wait_st(2, 1'b1, 40);
    chk(status[0] === 1'b0, "bad byte dropped");
    pulse(srd);
    repeat (2) @(posedge ref_clk);
    #1;
    chk(status[2] === 1'b0, "status read clears error");
  endtask : t_par

  // Break prefix is swallowed and folded into the next code
  task automatic t_xlat();
    xlat = 1'b1;
    kb.send(8'hF0, 1'b0);
    repeat (20) @(posedge ref_clk);
    #1;
    chk(status[0] === 1'b0, "prefix swallowed");
    kb.send(8'h1C, 1'b0);
    wait_st(0, 1'b1, 40);
    chk(odata === 8'h9C, "translated code");
    pulse(rd);
    xlat = 1'b0;
  endtask : t_xlat

  // Send with ack; a second write while busy must be ignored
  task automatic t_tx();
    irq_en = 1'b1;
    fork
      kb.recv(1'b1, fr);
      begin
        host_send(8'hA5);
        wait_st(1, 1'b1, 4);
        host_send(8'h33);
      end
    join
    chk(fr[8:1] === 8'hA5, "sent byte");
    chk(fr[0] === 1'b0 && fr[10] === 1'b1 && ^fr[9:1] === 1'b1, "odd frame");
    wait_st(1, 1'b0, 20);
    chk(status[3] === 1'b0, "no send error");
    kb.send(8'hFA, 1'b0);
    wait_st(0, 1'b1, 40);
    chk(irq === 1'b1 && odata === 8'hFA, "reply raises irq");
    pulse(rd);
    repeat (10) @(posedge ref_clk);
    #1;
    chk(status[1] === 1'b0 && c_oe === 1'b0, "busy write ignored");
  endtask : t_tx

  task automatic t_noack();
    fork
      kb.recv(1'b0, fr);
      host_send(8'h5A);
    join
    wait_st(3, 1'b1, 2100);
    chk(status[1] === 1'b0 && c_oe === 1'b0 && d_oe === 1'b0, "abort frees");
    pulse(srd);
  endtask : t_noack

  // No keyboard clocking at all: the send gives up and frees the buffer
  task automatic t_tmo();
    host_send(8'h96);
    wait_st(3, 1'b1, 6200);
    chk(status[1] === 1'b0 && c_oe === 1'b0 && d_oe === 1'b0, "timeout frees");
    pulse(srd);
  endtask : t_tmo

  // Reset in mid-send: the link and every flag fall back to idle
  task automatic t_rst();
    host_send(8'h11);
    repeat (5) @(posedge ref_clk);
    #1 rst = 1'b1;
    repeat (2) @(posedge ref_clk);
    #1 rst = 1'b0;
    repeat (3) @(posedge ref_clk);
    #1;
    chk(c_oe === 1'b0 && d_oe === 1'b0 && status === 8'h00, "mid-run reset idle");
  endtask : t_rst

  task automatic summarize();
    $display("mismatches=%0d n_checks=%0d", mismatches, n_checks);
    if (mismatches == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : summarize

  // 40 MHz system clock
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  // Main sequence; link syncs need three cycles after reset
  initial begin
    {rst, wr, rd, srd, irq_en, xlat, wdata} = {1'b1, 5'b0, 8'h00};
    repeat (4) @(posedge ref_clk);
    #1 rst = 1'b0;
    repeat (3) @(posedge ref_clk);
    #1;
    chk(c_oe === 1'b0 && d_oe === 1'b0 && status === 8'h00, "reset idle");
    t_rx(8'h00, 1'b0);
    t_rx(8'hFF, 1'b1);
    t_par();
    t_xlat();
    t_tx();
    t_noack();
    t_tmo();
    t_rst();
    summarize();
  end

  // Watchdog: whole run needs well under a millisecond
  initial begin
    #1000000;
    mismatches++;
    summarize();
  end
endmodule : test_keyboard_serial_controller
